// file: hdl/power_seq_pkg.sv
// Constants and types shared by the power-state sequencer
package power_seq_pkg;

  // Reference clock used to time the oscillator settle delay
  localparam int REF_CLK_HZ     = 32768;
  // Settle delays in milliseconds (least value of each window)
  localparam int LONG_DELAY_MS  = 16;
  localparam int SHORT_DELAY_MS = 4;
  // Settle delays in reference ticks, rounded up
  localparam int LONG_TICKS     = (LONG_DELAY_MS * REF_CLK_HZ + 999) / 1000;
  localparam int SHORT_TICKS    = (SHORT_DELAY_MS * REF_CLK_HZ + 999) / 1000;
  // Width of the settle tick counter
  localparam int TICK_CNT_W     = 10;

  // Reset values of software-visible control and status bits
  localparam logic RST_SUPPLY_REQUEST   = 1'b0;
  localparam logic RST_RAIL_ON          = 1'b0;
  localparam logic RST_CLOCK_GATE       = 1'b0;
  localparam logic RST_CORE_HALT        = 1'b0;
  localparam logic RST_ARMED            = 1'b0;
  localparam logic RST_ARMED_ENABLE     = 1'b0;
  localparam logic RST_OCCURRED         = 1'b0;
  localparam logic RST_SHORT_SELECT     = 1'b0;
  localparam logic RST_COLD_BOOT        = 1'b1;
  localparam logic RST_RESET_LATCH      = 1'b1;
  localparam logic RST_FIRST_UP         = 1'b1;

  // Power sequence states, Gray coded along off, rail, settle, run
  typedef enum logic [1:0] {
    ST_OFF    = 2'h0,
    ST_RAIL   = 2'h1,
    ST_SETTLE = 2'h3,
    ST_RUN    = 2'h2
  } seq_state_t;

endpackage : power_seq_pkg

// file: hdl/power_state_sequencer.sv
// Power-state sequencer: reset latch, power up/down, standby and forced off
//
// Summary of operation
// - Power-on reset sets the reset latch; first button press releases it.
// - While the reset latch is set, all control state stays at reset.
// - Button press raises supply request only while supply good is high.
// - First power up gates the system clock 16-24 ms after main rail rises.
// - Core may run only once the system clock gate is asserted.
// - Software clears supply request and rail-on together; request output drops.
// - Clearing rail-on drops the system clock gate and all fast clocks.
// - When off, button rise or enabled interrupt with supply good powers up.
// - Interrupt during low supply good is latched; power up when good returns.
// - Button press at low supply good is forgotten unless button interrupts enabled.
// - Gate low stops the core clock; core resumes where it stopped.
// - Later power ups wait 4-6 ms with short select set, else 16-24 ms.
// - Core halt bit stops the core clock until an enabled interrupt clears it.
// - Forced off acts only while the forced-off enable bit is set.
// - Power up from off sets the forced-off armed bit.
// - Supply good falling while armed drops the supply request.
// - A forced shutdown sets the occurred flag until software clears it.
// - Cold boot flag is set while the reset latch is active.
`timescale 1ns/1ps
`default_nettype none

module power_state_sequencer
  import power_seq_pkg::*;
#(
  parameter int LONG_TICKS_P  = power_seq_pkg::LONG_TICKS,  // Long settle, ref ticks
  parameter int SHORT_TICKS_P = power_seq_pkg::SHORT_TICKS  // Short settle, ref ticks
) (
  input  wire logic i_sys_clk,                // 10 MHz system clock
  input  wire logic i_arst_n,                 // Async reset, active low
  input  wire logic i_power_on_reset_n,       // Power-on reset pin, active low
  input  wire logic i_on_button,              // On-button pin, high when pressed
  input  wire logic i_supply_good,            // Supply good pin
  input  wire logic i_main_rail_status,       // Main rail powered pin
  input  wire logic i_ref_clk_32k,            // 32 kHz reference clock pin
  input  wire logic i_wake_irq,               // Enabled interrupt pending, level
  input  wire logic i_button_irq_enabled,     // Button rise irq enabled
  input  wire logic i_ctrl_wr,                // Control write strobe, one cycle
  input  wire logic i_wr_supply_request,      // Write data: supply request bit
  input  wire logic i_wr_rail_on,             // Write data: rail-on bit
  input  wire logic i_wr_core_clock_halt,     // Write data: core clock halt bit
  input  wire logic i_wr_forced_off_enable,   // Write data: forced-off enable
  input  wire logic i_wr_forced_off_armed,    // Write data: armed, 0 clears
  input  wire logic i_wr_forced_off_occurred, // Write data: occurred, 0 clears
  input  wire logic i_wr_short_delay_select,  // Write data: short settle select
  input  wire logic i_wr_cold_boot_flag,      // Write data: cold boot, 0 clears
  output logic      o_supply_request,         // Supply request pin
  output logic      o_rail_on,                // Rail-on bit
  output logic      o_system_clock_gate,      // System clock gate
  output logic      o_core_clock_en,          // Core clock enable
  output logic      o_core_clock_halt,        // Core clock halt bit
  output logic      o_forced_off_enable,      // Forced-off enable bit
  output logic      o_forced_off_armed,       // Forced-off armed bit
  output logic      o_forced_off_occurred,    // Forced-off occurred flag
  output logic      o_short_delay_select,     // Short settle select bit
  output logic      o_cold_boot_flag,         // Cold boot flag
  output logic      o_reset_active            // Reset latch set
);

  import power_seq_pkg::*;

  localparam logic [TICK_CNT_W-1:0] LONG_T  = TICK_CNT_W'(LONG_TICKS_P);
  localparam logic [TICK_CNT_W-1:0] SHORT_T = TICK_CNT_W'(SHORT_TICKS_P);

  // All state of the sequencer
  typedef struct packed {
    logic [1:0]            por_s;
    logic [1:0]            btn_s;
    logic [1:0]            good_s;
    logic [1:0]            rail_s;
    logic [1:0]            ref_s;
    logic                  btn_prev;
    logic                  good_prev;
    logic                  ref_prev;
    logic                  reset_latch;
    seq_state_t            state;
    logic                  first_up;
    logic                  wake_pending;
    logic [TICK_CNT_W-1:0] ticks;
    logic                  supply_request;
    logic                  rail_on;
    logic                  gate;
    logic                  core_en;
    logic                  halt;
    logic                  armed_enable;
    logic                  armed;
    logic                  occurred;
    logic                  short_sel;
    logic                  cold_boot;
  } seq_t;

  localparam seq_t RST_SEQ = '{
    por_s:          2'h0,
    btn_s:          2'h0,
    good_s:         2'h0,
    rail_s:         2'h0,
    ref_s:          2'h0,
    btn_prev:       1'b0,
    good_prev:      1'b0,
    ref_prev:       1'b0,
    reset_latch:    RST_RESET_LATCH,
    state:          ST_OFF,
    first_up:       RST_FIRST_UP,
    wake_pending:   1'b0,
    ticks:          '0,
    supply_request: RST_SUPPLY_REQUEST,
    rail_on:        RST_RAIL_ON,
    gate:           RST_CLOCK_GATE,
    core_en:        1'b0,
    halt:           RST_CORE_HALT,
    armed_enable:   RST_ARMED_ENABLE,
    armed:          RST_ARMED,
    occurred:       RST_OCCURRED,
    short_sel:      RST_SHORT_SELECT,
    cold_boot:      RST_COLD_BOOT
  };

  seq_t q;
  seq_t d;

  logic                  por_n;
  logic                  btn_rise;
  logic                  good;
  logic                  good_fall;
  logic                  ref_tick;
  logic                  wake_event;
  logic [TICK_CNT_W-1:0] target;

  // Synchronised pin levels and edges
  assign por_n     = q.por_s[1];
  assign good      = q.good_s[1];
  assign btn_rise  = q.btn_s[1] & ~q.btn_prev;
  assign good_fall = ~q.good_s[1] & q.good_prev;
  assign ref_tick  = q.ref_s[1] & ~q.ref_prev;
  // Wake sources; a button press is kept only if its irq is enabled
  assign wake_event = i_wake_irq | (btn_rise & i_button_irq_enabled);
  // Settle length: long on first power up or when short select is clear
  assign target = (q.first_up | ~q.short_sel) ? LONG_T : SHORT_T;

  // Next-state logic
  always_comb
  begin
    d = q;
    // Two-stage synchronisers and edge history
    d.por_s     = {q.por_s[0], i_power_on_reset_n};
    d.btn_s     = {q.btn_s[0], i_on_button};
    d.good_s    = {q.good_s[0], i_supply_good};
    d.rail_s    = {q.rail_s[0], i_main_rail_status};
    d.ref_s     = {q.ref_s[0], i_ref_clk_32k};
    d.btn_prev  = q.btn_s[1];
    d.good_prev = q.good_s[1];
    d.ref_prev  = q.ref_s[1];

    if (!por_n || q.reset_latch)
    begin
      // Hold every control bit at its reset value
      d.state          = RST_SEQ.state;
      d.first_up       = RST_SEQ.first_up;
      d.wake_pending   = RST_SEQ.wake_pending;
      d.ticks          = RST_SEQ.ticks;
      d.supply_request = RST_SEQ.supply_request;
      d.rail_on        = RST_SEQ.rail_on;
      d.gate           = RST_SEQ.gate;
      d.halt           = RST_SEQ.halt;
      d.armed_enable   = RST_SEQ.armed_enable;
      d.armed          = RST_SEQ.armed;
      d.occurred       = RST_SEQ.occurred;
      d.short_sel      = RST_SEQ.short_sel;
      d.cold_boot      = 1'b1;
      d.reset_latch    = 1'b1;
      // First press releases the latch and may power up at once
      if (por_n && btn_rise)
      begin
        d.reset_latch = 1'b0;
        if (good)
        begin
          d.supply_request = 1'b1;
          d.rail_on        = 1'b1;
          d.armed          = 1'b1;
          d.state          = ST_RAIL;
        end
      end
    end
    else
    begin
      // Software control write
      if (i_ctrl_wr)
      begin
        d.supply_request = i_wr_supply_request;
        d.rail_on        = i_wr_rail_on;
        d.halt           = i_wr_core_clock_halt;
        d.armed_enable   = i_wr_forced_off_enable;
        d.short_sel      = i_wr_short_delay_select;
        d.armed          = q.armed & i_wr_forced_off_armed;
        d.occurred       = q.occurred & i_wr_forced_off_occurred;
        d.cold_boot      = q.cold_boot & i_wr_cold_boot_flag;
        if (!i_wr_rail_on)
        begin
          d.gate  = 1'b0;
          d.ticks = '0;
          if (q.state != ST_OFF)
          begin
            d.state = ST_OFF;
          end
        end
      end

      // An enabled interrupt ends core halt
      if (i_wake_irq)
      begin
        d.halt = 1'b0;
      end

      unique case (q.state)
        ST_OFF:
        begin
          // Wake events are latched until supply good allows power up
          if (wake_event && !good)
          begin
            d.wake_pending = 1'b1;
          end
          if (good && (btn_rise || wake_event || q.wake_pending))
          begin
            d.supply_request = 1'b1;
            d.rail_on        = 1'b1;
            d.armed          = 1'b1;
            d.wake_pending   = 1'b0;
            d.halt           = 1'b0;
            d.ticks          = '0;
            d.state          = ST_RAIL;
          end
        end
        ST_RAIL:
        begin
          // Wait for the main rail to come up
          if (q.rail_s[1])
          begin
            d.ticks = '0;
            d.state = ST_SETTLE;
          end
        end
        ST_SETTLE:
        begin
          // Count reference ticks while the oscillator settles
          if (ref_tick)
          begin
            d.ticks = q.ticks + 1'b1;
          end
          if (q.ticks >= target)
          begin
            d.gate     = 1'b1;
            d.first_up = 1'b0;
            d.state    = ST_RUN;
          end
        end
        ST_RUN:
        begin
          d.ticks = q.ticks;
        end
      endcase

      // Supply good falling while armed forces the system off
      if (q.state != ST_OFF && q.armed && q.armed_enable && good_fall)
      begin
        d.supply_request = 1'b0;
        d.rail_on        = 1'b0;
        d.gate           = 1'b0;
        d.halt           = 1'b0;
        d.ticks          = '0;
        d.state          = ST_OFF;
        d.occurred       = 1'b1;
      end
    end

    // Core clock runs only with the gate up and halt clear
    d.core_en = d.gate & ~d.halt;
  end

  // State register
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      q <= RST_SEQ;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from state flops
  assign o_supply_request      = q.supply_request;
  assign o_rail_on             = q.rail_on;
  assign o_system_clock_gate   = q.gate;
  assign o_core_clock_en       = q.core_en;
  assign o_core_clock_halt     = q.halt;
  assign o_forced_off_enable   = q.armed_enable;
  assign o_forced_off_armed    = q.armed;
  assign o_forced_off_occurred = q.occurred;
  assign o_short_delay_select  = q.short_sel;
  assign o_cold_boot_flag      = q.cold_boot;
  assign o_reset_active        = q.reset_latch;

endmodule : power_state_sequencer

`default_nettype wire

// file: test/power_state_sequencer_monitor.sv
// Concurrent checks on the power-state sequencer ports
`timescale 1ns/1ps
`default_nettype none

module power_state_sequencer_monitor (
  input wire logic i_sys_clk, i_arst_n, i_supply_good,       // Clock, reset, supply good
  input wire logic i_main_rail_status, i_wake_irq, i_ctrl_wr, // Rail, wake, write strobe
  input wire logic i_wr_supply_request, i_wr_rail_on,        // Write data
  input wire logic i_wr_forced_off_occurred,                 // Write data, 0 clears
  input wire logic o_supply_request, o_rail_on,              // Request and rail-on
  input wire logic o_system_clock_gate, o_core_clock_en,     // Clock gates
  input wire logic o_core_clock_halt, o_forced_off_enable,   // Halt, forced-off enable
  input wire logic o_forced_off_armed, o_forced_off_occurred, // Armed, occurred
  input wire logic o_cold_boot_flag, o_reset_active          // Cold boot, reset latch
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  // Reset latch holds control state
  a_latch_holds_state: assert property (o_reset_active |->
    (!o_supply_request && !o_rail_on && !o_system_clock_gate && o_cold_boot_flag))
    else $error("control state moved while latched");
  a_core_enable_gated: assert property (o_core_clock_en ==
    (o_system_clock_gate && !o_core_clock_halt)) else $error("core clock enable wrong");
  a_gate_needs_rail: assert property (o_system_clock_gate |-> o_rail_on)
    else $error("clock gate high with rail-on low");
  // Software power down
  a_power_down_write: assert property (i_ctrl_wr && !o_reset_active && o_rail_on
    && !i_wr_supply_request |=> !o_supply_request) else $error("request kept after clear");
  a_rail_off_gate: assert property (i_ctrl_wr && !o_reset_active && o_rail_on
    && !i_wr_rail_on |=> !o_system_clock_gate && !o_rail_on) else $error("gate kept");
  a_request_arms: assert property ($rose(o_supply_request) |->
    o_forced_off_armed && o_rail_on) else $error("power up without armed bit");
  // Forced shutdown
  a_forced_off: assert property ($fell(i_supply_good) && o_forced_off_enable
    && o_forced_off_armed && o_rail_on |-> ##[1:6] (!o_supply_request && o_forced_off_occurred))
    else $error("no forced shutdown");
  a_forced_disabled: assert property (!o_forced_off_enable |=>
    !$rose(o_forced_off_occurred)) else $error("forced shutdown while disabled");
  a_occurred_sticky: assert property (o_forced_off_occurred && !o_reset_active &&
    !(i_ctrl_wr && !i_wr_forced_off_occurred) |=> o_forced_off_occurred)
    else $error("occurred flag lost");
  a_halt_wake: assert property (o_core_clock_halt && i_wake_irq |=> !o_core_clock_halt)
    else $error("halt not cleared by interrupt");
  a_settle_wait: assert property ($rose(i_main_rail_status) |=>
    !o_system_clock_gate [*8]) else $error("gate rose without settle");
endmodule : power_state_sequencer_monitor

bind power_state_sequencer power_state_sequencer_monitor i_mon (.*);

`default_nettype wire

// file: test/supply_model.sv
// External supply: main rail follows the request, free-running 32 kHz reference
`timescale 1ns/1ps
`default_nettype none

module supply_model #(
  parameter int RAIL_DLY = 20  // Cycles from request to rail up
) (
  input  wire logic i_sys_clk,          // System clock
  input  wire logic i_supply_request,   // Request from the device
  output var  logic o_main_rail_status, // Main rail powered
  output var  logic o_ref_clk_32k       // Reference clock
);
  int cnt;

  // Reference oscillator runs free
  initial o_ref_clk_32k = 1'b0;
  always #15259 o_ref_clk_32k = ~o_ref_clk_32k;

  // Rail ramps after a delay, drops at once on release
  initial o_main_rail_status = 1'b0;
  always @(negedge i_sys_clk)
  begin
    if (!i_supply_request)
    begin
      cnt <= 0;
      o_main_rail_status <= 1'b0;
    end
    else if (cnt == RAIL_DLY)
      o_main_rail_status <= 1'b1;
    else
      cnt <= cnt + 1;
  end
endmodule : supply_model

`default_nettype wire

// file: test/power_state_sequencer_tb_top.sv
// Self-checking bench of the power-state sequencer
`timescale 1ns/1ps
`default_nettype none

module power_state_sequencer_tb_top;
  import power_seq_pkg::*;
  localparam int LT = 4, ST = 2, REF_CYC = 305;
  logic clk = 1'b0, arst_n = 1'b0, pon_n = 1'b0, btn = 1'b0, good = 1'b0, wake = 1'b0;
  logic irq_en = 1'b0, wr = 1'b0, w_sr = 1'b0, w_ro = 1'b0, w_ha = 1'b0, w_fe = 1'b0;
  logic w_ar = 1'b0, w_oc = 1'b0, w_ss = 1'b0, w_cb = 1'b0, rail, ref32;
  logic sr, ro, gate, core_en, halt, fen, armed, occ, ssel, cold, rst_act;
  int failures = 0, n_compared = 0;
  int unsigned seed = 32'h8B2F;

  always #50 clk = ~clk;

  power_state_sequencer #(.LONG_TICKS_P(LT), .SHORT_TICKS_P(ST)) i_dut (
    .i_sys_clk(clk), .i_arst_n(arst_n), .i_power_on_reset_n(pon_n), .i_on_button(btn),
    .i_supply_good(good), .i_main_rail_status(rail), .i_ref_clk_32k(ref32),
    .i_wake_irq(wake), .i_button_irq_enabled(irq_en), .i_ctrl_wr(wr),
    .i_wr_supply_request(w_sr), .i_wr_rail_on(w_ro), .i_wr_core_clock_halt(w_ha),
    .i_wr_forced_off_enable(w_fe), .i_wr_forced_off_armed(w_ar),
    .i_wr_forced_off_occurred(w_oc), .i_wr_short_delay_select(w_ss),
    .i_wr_cold_boot_flag(w_cb), .o_supply_request(sr), .o_rail_on(ro),
    .o_system_clock_gate(gate), .o_core_clock_en(core_en), .o_core_clock_halt(halt),
    .o_forced_off_enable(fen), .o_forced_off_armed(armed), .o_forced_off_occurred(occ),
    .o_short_delay_select(ssel), .o_cold_boot_flag(cold), .o_reset_active(rst_act));

  supply_model #(.RAIL_DLY(20)) i_supply (.i_sys_clk(clk), .i_supply_request(sr),
    .o_main_rail_status(rail), .o_ref_clk_32k(ref32));

  // Xorshift source
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Settle window in system cycles for a tick count
  function automatic logic in_window(input int n, input int t);
    return (n >= (t - 1) * REF_CYC) && (n <= (t + 1) * REF_CYC + 10);
  endfunction : in_window

  task automatic chk(input string nm, input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk

  task automatic print_verdict();
    if (failures == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // One control write: supply, rail-on, halt, enable, armed, occurred, short select
  task automatic wrc(input logic a, b, c, d, e, f, g);
    @(negedge clk);
    {w_sr, w_ro, w_ha, w_fe, w_ar, w_oc, w_ss} = {a, b, c, d, e, f, g};
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wrc

  task automatic press();
    @(negedge clk);
    btn = 1'b1;
    cyc(4 + rnd() % 8);
    btn = 1'b0;
    cyc(4);
  endtask : press

  // Request, rail, then gate after the settle count
  task automatic wait_up(input int t);
    int n;
    n = 0;
    while (sr !== 1'b1 && n < 50)
    begin
      cyc(1);
      n++;
    end
    chk("supply_request", sr, 1'b1);
    chk("forced_off_armed", armed, 1'b1);
    chk("rail_on", ro, 1'b1);
    while (rail !== 1'b1 && n < 200)
    begin
      cyc(1);
      n++;
    end
    n = 0;
    while (gate !== 1'b1 && n < 4000)
    begin
      cyc(1);
      n++;
    end
    chk("gate_delay", in_window(n, t), 1'b1);
    chk("core_clock_en", core_en, 1'b1);
  endtask : wait_up

  // Watchdog
  initial
  begin
    cyc(30000);
    failures++;
    print_verdict();
  end

  initial
  begin
    cyc(10);
    arst_n = 1'b1;
    chk("reset_active", rst_act, 1'b1);
    chk("cold_boot_flag", cold, 1'b1);
    pon_n = 1'b1;
    cyc(10);
    wrc(1, 1, 0, 0, 1, 1, 0);
    chk("rail_on", ro, 1'b0);
    chk("reset_active", rst_act, 1'b1);
    press();
    chk("reset_active", rst_act, 1'b0);
    chk("supply_request", sr, 1'b0);
    good = 1'b1;
    cyc(20);
    chk("supply_request", sr, 1'b0);
    press();
    wait_up(LT);
    // Cold boot flag kept by a write of one, cleared by a write of zero
    w_cb = 1'b1;
    wrc(1, 1, 0, 1, 1, 1, 0);
    chk("cold_boot_flag", cold, 1'b1);
    chk("forced_off_enable", fen, 1'b1);
    w_cb = 1'b0;
    wrc(1, 1, 0, 1, 1, 1, 0);
    chk("cold_boot_flag", cold, 1'b0);
    good = 1'b0;
    cyc(8);
    chk("supply_request", sr, 1'b0);
    chk("occurred", occ, 1'b1);
    chk("gate", gate, 1'b0);
    wrc(0, 0, 0, 1, 1, 0, 0);
    chk("occurred", occ, 1'b0);
    // Wake at low supply good: interrupt, then button with its interrupt enabled
    for (int src = 0; src < 2; src++)
    begin
      if (src == 0)
      begin
        wake = 1'b1;
        cyc(3);
        wake = 1'b0;
      end
      else
      begin
        irq_en = 1'b1;
        press();
      end
      cyc(10 + rnd() % 20);
      chk("supply_request", sr, 1'b0);
      good = 1'b1;
      wait_up(LT);
      irq_en = 1'b0;
      wrc(1, 1, 0, 1, 0, 1, 0);
      chk("forced_off_armed", armed, 1'b0);
      wrc(0, 0, 0, 1, 0, 1, 0);
      chk("supply_request", sr, 1'b0);
      chk("gate", gate, 1'b0);
      good = 1'b0;
      cyc(5);
    end
    good = 1'b1;
    wrc(0, 0, 0, 0, 0, 1, 1);
    chk("forced_off_enable", fen, 1'b0);
    chk("short_delay_select", ssel, 1'b1);
    press();
    wait_up(ST);
    good = 1'b0;
    cyc(8);
    chk("supply_request", sr, 1'b1);
    good = 1'b1;
    // Standby entry and wake with random spacing
    repeat (4)
    begin
      wrc(1, 1, 1, 0, 1, 1, 1);
      chk("core_clock_en", core_en, 1'b0);
      cyc(1 + rnd() % 16);
      chk("core_clock_halt", halt, 1'b1);
      wake = 1'b1;
      cyc(1);
      wake = 1'b0;
      cyc(3);
      chk("core_clock_halt", halt, 1'b0);
      chk("core_clock_en", core_en, 1'b1);
    end
    // Power-on reset pin again mid-run: latch set, first press powers up
    pon_n = 1'b0;
    cyc(4);
    chk("reset_active", rst_act, 1'b1);
    chk("cold_boot_flag", cold, 1'b1);
    chk("supply_request", sr, 1'b0);
    chk("short_delay_select", ssel, 1'b0);
    pon_n = 1'b1;
    cyc(4);
    press();
    chk("reset_active", rst_act, 1'b0);
    wait_up(LT);
    print_verdict();
  end
endmodule : power_state_sequencer_tb_top

`default_nettype wire
